// ---- afr_chan.sv ----
// one analog channel: low-pass filter, two-point scaling, quantizer with hysteresis
`timescale 1ns/1ps
`include "afr_defines.svh"
module afr_chan import afr_pkg::*; #(
    parameter int FB = `AFR_ACC_FRAC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire afr_val_t sample_i,
    input wire logic bipolar_i,
    input wire logic [13:0] filt_ms_i,
    input wire afr_val_t px1_i,
    input wire afr_val_t py1_i,
    input wire afr_val_t px2_i,
    input wire afr_val_t py2_i,
    input wire afr_val_t nx1_i,
    input wire afr_val_t ny1_i,
    input wire afr_val_t nx2_i,
    input wire afr_val_t ny2_i,
    input wire logic [15:0] qstep_i,
    output logic [15:0] mag_o,
    output logic neg_o
);
    logic signed [31:0] acc_q, acc_d, diff, x, x1, y1, x2, y2, pct;
    logic [13:0] tau;
    afr_val_t filt;
    logic neg_seg, neg_q, neg_d;
    logic [15:0] scl_q, scl_d, lvl_q, lvl_d, q;
    logic [17:0] up_thr, down_cmp;

    // filter: each millisecond tick moves 1/(tau+1) of the way to the sample
    always_comb begin
        tau = (filt_ms_i > `AFR_FILT_MAX_MS) ? `AFR_FILT_MAX_MS : filt_ms_i;
        diff = (32'(sample_i) <<< FB) - acc_q;
        acc_d = acc_q;
        if (tick_i) begin
            acc_d = acc_q + diff / $signed({18'h0, tau} + 32'sd1);
        end
    end
    assign filt = acc_q[FB+15:FB];

    // scaling: positive segment, or the negative one only in bipolar mode
    always_comb begin
        neg_seg = (bipolar_i == `AFR_POL_BIPOLAR) && (filt < 0);
        x = (filt < 0 && !neg_seg) ? 32'sd0 : 32'(filt);
        x1 = neg_seg ? 32'(nx1_i) : 32'(px1_i);
        y1 = neg_seg ? 32'(ny1_i) : 32'(py1_i);
        x2 = neg_seg ? 32'(nx2_i) : 32'(px2_i);
        y2 = neg_seg ? 32'(ny2_i) : 32'(py2_i);
        if (x2 == x1) begin
            pct = y1;
        end else begin
            pct = y1 + ((x - x1) * (y2 - y1)) / (x2 - x1);
        end
        if (neg_seg) begin
            if (pct < -`AFR_PCT_FULL) begin
                pct = -`AFR_PCT_FULL;
            end else if (pct > 32'sd0) begin
                pct = 32'sd0;
            end
        end else begin
            if (pct > `AFR_PCT_FULL) begin
                pct = `AFR_PCT_FULL;
            end else if (pct < 32'sd0) begin
                pct = 32'sd0;
            end
        end
        neg_d = pct < 32'sd0;
        scl_d = neg_d ? 16'(-pct) : 16'(pct);
    end

    // quantizer: up after three quarters of a step, down after falling a quarter below the rise point
    always_comb begin
        q = (qstep_i < `AFR_QSTEP_MIN) ? `AFR_QSTEP_MIN : ((qstep_i > `AFR_QSTEP_MAX) ? `AFR_QSTEP_MAX : qstep_i);
        up_thr = {2'b00, lvl_q} + {2'b00, q} - {4'b0000, q[15:2]};
        down_cmp = {2'b00, scl_q} + {3'b000, q[15:1]};
        lvl_d = lvl_q;
        if ({2'b00, scl_q} >= up_thr) begin
            lvl_d = lvl_q + q;
        end else if (lvl_q >= q && down_cmp < {2'b00, lvl_q}) begin
            lvl_d = lvl_q - q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q <= 32'sd0;
            scl_q <= 16'h0000;
            neg_q <= 1'b0;
            lvl_q <= 16'h0000;
        end else if (ce_i) begin
            acc_q <= acc_d;
            scl_q <= scl_d;
            neg_q <= neg_d;
            lvl_q <= lvl_d;
        end
    end

    assign mag_o = lvl_q;
    assign neg_o = neg_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    filt_pass_a: assert property (ce_i && tick_i && filt_ms_i == 14'h0000 |=> filt == $past(sample_i))
        else $error("zero time constant did not pass the sample");
    quant_whole_a: assert property (ce_i && lvl_d != lvl_q |=> (lvl_q == $past(lvl_q) + $past(q))
        || (lvl_q == $past(lvl_q) - $past(q)))
        else $error("quantized level moved by other than one step");
    hyst_hold_a: assert property (ce_i && {2'b00, scl_q} < up_thr && down_cmp >= {2'b00, lvl_q}
        |=> $stable(lvl_q))
        else $error("quantized level moved inside the hysteresis band");
    unipolar_pos_a: assert property (ce_i && bipolar_i == `AFR_POL_UNIPOLAR |=> !neg_o)
        else $error("unipolar input produced a negative reference");
endmodule

// ---- afr_defines.svh ----
// constants of the analog frequency reference block
`ifndef AFR_DEFINES_SVH
`define AFR_DEFINES_SVH
`define AFR_SRC_KEY_NUM 4'h0
`define AFR_SRC_KEY_UPDN 4'h1
`define AFR_SRC_VOLT 4'h2
`define AFR_SRC_CURR 4'h3
`define AFR_POL_UNIPOLAR 1'b0
`define AFR_POL_BIPOLAR 1'b1
`define AFR_INVERT_YES 1'b1
`define AFR_PCT_FULL 32'sh0000_2710
`define AFR_QSTEP_MIN 16'h0004
`define AFR_QSTEP_MAX 16'h03e8
`define AFR_FILT_MAX_MS 14'h2710
`define AFR_ACC_FRAC 8
`define AFR_CLK_PERIOD_NS 8
`define AFR_FILT_TICK_NS 1000000
`define AFR_KEY_STEP 16'h0001
`define AFR_CMD_FREQ_RST 16'h0000
`endif

// ---- afr_partner.sv ----
// keypad and analog source model facing the reference block
`timescale 1ns/1ps
module afr_partner import afr_pkg::*; (
    input wire logic clk_i,
    output logic [3:0] keys_o,
    output afr_val_t volt_o,
    output afr_val_t curr_o
);
    initial begin
        keys_o = 4'h0;
        volt_o = 16'sh0000;
        curr_o = 16'sh0000;
    end
    // one-cycle key pulse: 0 commit, 1 discard, 2 up, 3 down
    task automatic press(input int k);
        @(posedge clk_i);
        keys_o <= 4'h1 << k;
        @(posedge clk_i);
        keys_o <= 4'h0;
    endtask
    // sources are driven, never released, so they always hold a level
    task automatic drive(input afr_val_t v, input afr_val_t c);
        @(posedge clk_i);
        volt_o <= v;
        curr_o <= c;
    endtask
endmodule

// ---- afr_pkg.sv ----
// types of the analog frequency reference block
package afr_pkg;
    typedef enum logic {
        AFR_EDIT_IDLE,
        AFR_EDIT_LIVE
    } afr_edit_t;
    typedef logic signed [15:0] afr_val_t;
endpackage

// ---- afr_store.sv ----
// holder of the committed keypad frequency
`timescale 1ns/1ps
`include "afr_defines.svh"
module afr_store #(
    parameter int W = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic wr_i,
    input wire logic [W-1:0] wdata_i,
    output logic [W-1:0] rdata_o
);
    logic [W-1:0] mem_q;
    logic [W-1:0] mem_d;

    always_comb begin
        mem_d = mem_q;
        if (wr_i) begin
            mem_d = wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_q <= W'(`AFR_CMD_FREQ_RST);
        end else if (ce_i) begin
            mem_q <= mem_d;
        end
    end

    assign rdata_o = mem_q;
endmodule

// ---- afr_top.sv ----
// analog frequency reference: source select, keypad editing, scaling and direction
// Function
// - selector 1 picks keypad up/down, 2 the voltage input, 3 the current input.
// - selector 0 takes a typed keypad value, stored when commit key pressed.
// - up/down edit changes frequency live; commit key stores, discard key drops.
// - voltage input is 0..+10 V or -10..+10 V; bipolar sign sets direction.
// - polarity 0 unipolar, 1 bipolar; negative segment only used when bipolar.
// - 100 percent gives full-scale frequency, limited to the maximum frequency.
// - positive voltage segment maps linearly between two voltage/percent points.
// - bipolar negative segment maps linearly through its own two points.
// - voltage input low-pass filtered, time constant 0..10000 ms to 63 percent.
// - voltage invert option set reverses the commanded rotation direction.
// - quantizing step 0.04..10 percent; command moves only in whole steps.
// - quantizer rises after three quarters step, falls after quarter-step drop.
// - bipolar: forward run plus negative input turns reverse; reverse run mirrors.
// - current input 0..20 mA maps linearly between two current/percent points.
// - full-scale frequency also applies to the current input at 100 percent.
// - current input has its own first-order low-pass filter.
// - current input has direction invert and the same quantizer.
// - present voltage and current inputs are readable as monitor values.
`timescale 1ns/1ps
`include "afr_defines.svh"
module afr_top import afr_pkg::*; #(
    parameter int FW = 16,
    parameter int TICK_CYCLES = `AFR_FILT_TICK_NS / `AFR_CLK_PERIOD_NS,
    parameter logic [15:0] KEY_STEP = `AFR_KEY_STEP
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [3:0] ref_src_sel_i,
    input wire logic [FW-1:0] max_freq_i,
    input wire logic [FW-1:0] full_scale_frequency_i,
    input wire logic [FW-1:0] key_value_i,
    input wire logic commit_key_i,
    input wire logic discard_key_i,
    input wire logic up_key_i,
    input wire logic down_key_i,
    input wire logic forward_run_i,
    input wire logic reverse_run_i,
    input wire afr_val_t voltage_ref_input_i,
    input wire logic voltage_polarity_select_i,
    input wire logic [13:0] voltage_filter_time_i,
    input wire afr_val_t volt_pos_x1_i,
    input wire afr_val_t volt_pos_y1_i,
    input wire afr_val_t volt_pos_x2_i,
    input wire afr_val_t volt_pos_y2_i,
    input wire afr_val_t volt_neg_x1_i,
    input wire afr_val_t volt_neg_y1_i,
    input wire afr_val_t volt_neg_x2_i,
    input wire afr_val_t volt_neg_y2_i,
    input wire logic voltage_direction_invert_i,
    input wire logic [15:0] voltage_quant_step_i,
    input wire afr_val_t current_ref_input_i,
    input wire logic [13:0] current_filter_time_i,
    input wire afr_val_t curr_x1_i,
    input wire afr_val_t curr_y1_i,
    input wire afr_val_t curr_x2_i,
    input wire afr_val_t curr_y2_i,
    input wire logic current_direction_invert_i,
    input wire logic [15:0] current_quant_step_i,
    output logic [FW-1:0] freq_cmd_o,
    output logic dir_reverse_o,
    output logic editing_o,
    output logic [FW-1:0] stored_freq_o,
    output afr_val_t voltage_readback_o,
    output afr_val_t current_readback_o
);
    afr_edit_t st_q, st_d;
    logic [FW-1:0] edit_q, edit_d, wdata, key_clamped, stored, fs, key_freq, freq_q, freq_d;
    logic wr;
    logic [FW:0] edit_up;
    logic [31:0] tick_cnt_q, tick_cnt_d;
    logic tick_q, tick_d;
    logic [15:0] v_mag, c_mag, a_mag;
    logic v_neg, c_neg, a_rev, dir_q, dir_d;
    logic [FW+16:0] prod;
    logic [FW+16:0] a_freq;
    afr_val_t vrb_q, crb_q;

    // millisecond tick for both filters
    always_comb begin
        tick_d = 1'b0;
        tick_cnt_d = tick_cnt_q + 32'd1;
        if (tick_cnt_q >= 32'(TICK_CYCLES - 1)) begin
            tick_cnt_d = 32'd0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_q <= 32'd0;
            tick_q <= 1'b0;
        end else if (ce_i) begin
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
        end
    end

    afr_chan u_volt (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .tick_i(tick_q),
        .sample_i(voltage_ref_input_i),
        .bipolar_i(voltage_polarity_select_i),
        .filt_ms_i(voltage_filter_time_i),
        .px1_i(volt_pos_x1_i),
        .py1_i(volt_pos_y1_i),
        .px2_i(volt_pos_x2_i),
        .py2_i(volt_pos_y2_i),
        .nx1_i(volt_neg_x1_i),
        .ny1_i(volt_neg_y1_i),
        .nx2_i(volt_neg_x2_i),
        .ny2_i(volt_neg_y2_i),
        .qstep_i(voltage_quant_step_i),
        .mag_o(v_mag),
        .neg_o(v_neg)
    );

    // current input is never bipolar, so its negative segment is unused
    afr_chan u_curr (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .tick_i(tick_q),
        .sample_i(current_ref_input_i),
        .bipolar_i(`AFR_POL_UNIPOLAR),
        .filt_ms_i(current_filter_time_i),
        .px1_i(curr_x1_i),
        .py1_i(curr_y1_i),
        .px2_i(curr_x2_i),
        .py2_i(curr_y2_i),
        .nx1_i(16'sh0000),
        .ny1_i(16'sh0000),
        .nx2_i(16'sh0000),
        .ny2_i(16'sh0000),
        .qstep_i(current_quant_step_i),
        .mag_o(c_mag),
        .neg_o(c_neg)
    );

    afr_store #(.W(FW)) u_store (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .wr_i(wr),
        .wdata_i(wdata),
        .rdata_o(stored)
    );

    // keypad entry and up/down edit session
    always_comb begin
        key_clamped = (key_value_i > max_freq_i) ? max_freq_i : key_value_i;
        edit_up = {1'b0, edit_q} + {1'b0, KEY_STEP};
        st_d = st_q;
        edit_d = edit_q;
        wr = 1'b0;
        wdata = key_clamped;
        case (st_q)
            AFR_EDIT_IDLE: begin
                if (ref_src_sel_i == `AFR_SRC_KEY_NUM && commit_key_i) begin
                    wr = 1'b1;
                end else if (ref_src_sel_i == `AFR_SRC_KEY_UPDN && commit_key_i) begin
                    st_d = AFR_EDIT_LIVE;
                    edit_d = stored;
                end
            end
            AFR_EDIT_LIVE: begin
                if (ref_src_sel_i != `AFR_SRC_KEY_UPDN) begin
                    st_d = AFR_EDIT_IDLE;
                end else if (commit_key_i) begin
                    wr = 1'b1;
                    wdata = edit_q;
                    st_d = AFR_EDIT_IDLE;
                end else if (discard_key_i) begin
                    st_d = AFR_EDIT_IDLE;
                    edit_d = stored;
                end else if (up_key_i) begin
                    edit_d = (edit_up > {1'b0, max_freq_i}) ? max_freq_i : edit_up[FW-1:0];
                end else if (down_key_i) begin
                    edit_d = (edit_q > KEY_STEP) ? edit_q - KEY_STEP : '0;
                end
            end
            default: begin
                st_d = AFR_EDIT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= AFR_EDIT_IDLE;
            edit_q <= '0;
        end else if (ce_i) begin
            st_q <= st_d;
            edit_q <= edit_d;
        end
    end

    // frequency and direction from the selected source
    always_comb begin
        fs = (full_scale_frequency_i > max_freq_i) ? max_freq_i : full_scale_frequency_i;
        a_mag = (ref_src_sel_i == `AFR_SRC_CURR) ? c_mag : v_mag;
        prod = (FW+17)'(a_mag) * (FW+17)'(fs);
        a_freq = prod / (FW+17)'(`AFR_PCT_FULL);
        if (ref_src_sel_i == `AFR_SRC_CURR) begin
            a_rev = c_neg ^ (current_direction_invert_i == `AFR_INVERT_YES);
        end else begin
            a_rev = v_neg ^ (voltage_direction_invert_i == `AFR_INVERT_YES);
        end
        key_freq = (st_q == AFR_EDIT_LIVE) ? edit_q : stored;
        freq_d = '0;
        case (ref_src_sel_i)
            `AFR_SRC_KEY_NUM, `AFR_SRC_KEY_UPDN: begin
                freq_d = key_freq;
            end
            `AFR_SRC_VOLT, `AFR_SRC_CURR: begin
                freq_d = (a_freq > (FW+17)'(max_freq_i)) ? max_freq_i : a_freq[FW-1:0];
            end
            default: begin
                freq_d = '0;
            end
        endcase
        if (freq_d > max_freq_i) begin
            freq_d = max_freq_i;
        end
        dir_d = reverse_run_i && !forward_run_i;
        if (ref_src_sel_i == `AFR_SRC_VOLT || ref_src_sel_i == `AFR_SRC_CURR) begin
            dir_d = dir_d ^ a_rev;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            freq_q <= '0;
            dir_q <= 1'b0;
            vrb_q <= 16'sh0000;
            crb_q <= 16'sh0000;
        end else if (ce_i) begin
            freq_q <= freq_d;
            dir_q <= dir_d;
            vrb_q <= voltage_ref_input_i;
            crb_q <= current_ref_input_i;
        end
    end

    assign freq_cmd_o = freq_q;
    assign dir_reverse_o = dir_q;
    assign editing_o = (st_q == AFR_EDIT_LIVE);
    assign stored_freq_o = stored;
    assign voltage_readback_o = vrb_q;
    assign current_readback_o = crb_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence enter_edit_s;
        ce_i && st_q == AFR_EDIT_IDLE && ref_src_sel_i == `AFR_SRC_KEY_UPDN && commit_key_i;
    endsequence
    sequence live_up_s;
        ce_i && st_q == AFR_EDIT_LIVE && ref_src_sel_i == `AFR_SRC_KEY_UPDN && !commit_key_i
            && !discard_key_i && up_key_i && {1'b0, edit_q} + {1'b0, KEY_STEP} <= {1'b0, max_freq_i};
    endsequence
    sequence live_commit_s;
        ce_i && st_q == AFR_EDIT_LIVE && ref_src_sel_i == `AFR_SRC_KEY_UPDN && commit_key_i;
    endsequence

    max_clamp_a: assert property ($past(ce_i) |-> freq_cmd_o <= $past(max_freq_i))
        else $error("frequency command above maximum frequency");
    key_store_a: assert property (ce_i && st_q == AFR_EDIT_IDLE && ref_src_sel_i == `AFR_SRC_KEY_NUM
        && commit_key_i |=> stored_freq_o == $past(key_clamped))
        else $error("typed keypad value was not stored");
    edit_enter_a: assert property (enter_edit_s |=> editing_o && edit_q == $past(stored))
        else $error("edit session did not start from the stored value");
    edit_live_a: assert property (live_up_s |=> edit_q == $past(edit_q) + KEY_STEP
        ##1 !ce_i || freq_cmd_o == $past(edit_q) || !editing_o)
        else $error("up key did not change the live command");
    edit_drop_a: assert property (ce_i && editing_o && ref_src_sel_i == `AFR_SRC_KEY_UPDN
        && !commit_key_i && discard_key_i |=> !editing_o && $stable(stored_freq_o))
        else $error("discard key changed the stored value");
    volt_dir_a: assert property (ce_i && ref_src_sel_i == `AFR_SRC_VOLT && forward_run_i
        |=> dir_reverse_o == ($past(v_neg) ^ $past(voltage_direction_invert_i)))
        else $error("voltage sign or inversion did not set the direction");
    curr_scale_a: assert property (ce_i && ref_src_sel_i == `AFR_SRC_CURR && c_mag == 16'h2710
        |=> freq_cmd_o == $past(fs))
        else $error("full current did not give the full-scale frequency");
    readback_a: assert property (ce_i |=> voltage_readback_o == $past(voltage_ref_input_i)
        && current_readback_o == $past(current_ref_input_i))
        else $error("monitor value does not follow the input");
    edit_commit_a: assert property (live_commit_s |=> !editing_o && stored_freq_o == $past(edit_q))
        else $error("commit key did not store the edited value");
    edit_down_a: assert property (ce_i && st_q == AFR_EDIT_LIVE && ref_src_sel_i == `AFR_SRC_KEY_UPDN
        && !commit_key_i && !discard_key_i && !up_key_i && down_key_i && edit_q > KEY_STEP
        |=> edit_q == $past(edit_q) - KEY_STEP)
        else $error("down key did not lower the edited value by one step");
    src_other_a: assert property (ce_i && ref_src_sel_i > `AFR_SRC_CURR |=> freq_cmd_o == '0)
        else $error("unsupported source gave a nonzero command");
    curr_dir_a: assert property (ce_i && ref_src_sel_i == `AFR_SRC_CURR && forward_run_i
        |=> dir_reverse_o == ($past(c_neg) ^ $past(current_direction_invert_i)))
        else $error("current inversion did not set the direction");
endmodule

// ---- tb.sv ----
// self-checking bench of the analog frequency reference
`timescale 1ns/1ps
module tb import afr_pkg::*; ;
    typedef struct packed {logic [15:0] f; logic d;} afr_note_t;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce = 1'b1;
    logic [3:0] sel = 4'h0;
    logic [15:0] maxf = 16'h1770, fs = 16'h1770, kval = 16'h0000;
    logic forward_run = 1'b1, reverse_run = 1'b0, pol = 1'b0, vinv = 1'b0, cinv = 1'b0, look = 1'b0;
    logic [13:0] vft = 14'h0000, cft = 14'h0000;
    logic [15:0] vq = 16'h03e8, cq = 16'h03e8;
    afr_val_t pt [12] = '{16'sh0, 16'sh0, 16'sh03e8, 16'sh2710, 16'sh0, 16'sh0, -16'sh03e8, -16'sh2710,
        16'sh0190, 16'sh0, 16'sh07d0, 16'sh2710};
    logic [3:0] keys;
    afr_val_t volt, curr, vrb, crb, rv, rc;
    logic [15:0] freq, stored;
    logic dir, edit;
    afr_note_t notes [$];
    afr_note_t n;
    int mismatches = 0;
    int samples_checked = 0;

    initial forever #4 clk_i = ~clk_i;

    afr_partner afr_partner_i (.clk_i(clk_i), .keys_o(keys), .volt_o(volt), .curr_o(curr));

    afr_top #(.TICK_CYCLES(4)) afr_top_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .ref_src_sel_i(sel), .max_freq_i(maxf),
        .full_scale_frequency_i(fs), .key_value_i(kval), .commit_key_i(keys[0]), .discard_key_i(keys[1]),
        .up_key_i(keys[2]), .down_key_i(keys[3]), .forward_run_i(forward_run), .reverse_run_i(reverse_run),
        .voltage_ref_input_i(volt), .voltage_polarity_select_i(pol), .voltage_filter_time_i(vft),
        .volt_pos_x1_i(pt[0]), .volt_pos_y1_i(pt[1]), .volt_pos_x2_i(pt[2]), .volt_pos_y2_i(pt[3]),
        .volt_neg_x1_i(pt[4]), .volt_neg_y1_i(pt[5]), .volt_neg_x2_i(pt[6]), .volt_neg_y2_i(pt[7]),
        .voltage_direction_invert_i(vinv), .voltage_quant_step_i(vq), .current_ref_input_i(curr),
        .current_filter_time_i(cft), .curr_x1_i(pt[8]), .curr_y1_i(pt[9]), .curr_x2_i(pt[10]),
        .curr_y2_i(pt[11]), .current_direction_invert_i(cinv), .current_quant_step_i(cq),
        .freq_cmd_o(freq), .dir_reverse_o(dir), .editing_o(edit), .stored_freq_o(stored),
        .voltage_readback_o(vrb), .current_readback_o(crb)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_n(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    // queue the expected command; the monitor compares at the falling edge after the next rise
    task automatic note(input logic [15:0] f, input logic d);
        notes.push_back('{f, d});
        @(posedge clk_i);
        look <= 1'b1;
        @(posedge clk_i);
        look <= 1'b0;
    endtask

    always @(negedge clk_i) begin
        if (look) begin
            n = notes.pop_front();
            check(freq, n.f);
            check({15'h0, dir}, {15'h0, n.d});
        end
    end

    task automatic ana(input afr_val_t v, input afr_val_t c, input logic [15:0] f, input logic d);
        afr_partner_i.drive(v, c);
        wait_n(30);
        note(f, d);
    endtask

    // step from rest: partway after ten ticks, on a whole step, then full scale
    task automatic filt(input afr_val_t v, input afr_val_t c, input logic [15:0] f);
        afr_partner_i.drive(v, c);
        wait_n(40);
        @(negedge clk_i);
        check({15'h0, freq < f}, 16'h0001);
        check(freq % (f / 16'h000a), 16'h0000);
        wait_n(1000);
        note(f, 1'b0);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        wait_n(20000);
        mismatches++;
        $display("ERROR %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        void'($urandom(83742));
        wait_n(20);
        rst_n_i <= 1'b1;
        wait_n(2);
        note(16'h0000, 1'b0);
        kval <= 16'h1b58;
        afr_partner_i.press(0);
        wait_n(3);
        note(16'h1770, 1'b0);
        check(stored, 16'h1770);
        kval <= 16'h04d2;
        afr_partner_i.press(0);
        wait_n(3);
        note(16'h04d2, 1'b0);
        $display("typed keypad done");
        sel <= 4'h1;
        afr_partner_i.press(0);
        wait_n(2);
        @(negedge clk_i);
        check({15'h0, edit}, 16'h0001);
        for (int i = 0; i < 3; i++) afr_partner_i.press(2);
        wait_n(3);
        note(16'h04d5, 1'b0);
        afr_partner_i.press(1);
        wait_n(3);
        check(stored, 16'h04d2);
        note(16'h04d2, 1'b0);
        afr_partner_i.press(0);
        afr_partner_i.press(3);
        afr_partner_i.press(0);
        wait_n(3);
        check(stored, 16'h04d1);
        forward_run <= 1'b0;
        reverse_run <= 1'b1;
        wait_n(3);
        note(16'h04d1, 1'b1);
        forward_run <= 1'b1;
        reverse_run <= 1'b0;
        $display("up/down keypad done");
        sel <= 4'h2;
        ana(16'sh03e8, 16'sh0, 16'h1770, 1'b0);
        pt[3] <= 16'sh1388;
        ana(16'sh03e8, 16'sh0, 16'h0bb8, 1'b0);
        pt[3] <= 16'sh2710;
        ana(-16'sh01f4, 16'sh0, 16'h0000, 1'b0);
        ana(16'sh023f, 16'sh0, 16'h0e10, 1'b0);
        ana(16'sh023a, 16'sh0, 16'h0e10, 1'b0);
        ana(16'sh0225, 16'sh0, 16'h0bb8, 1'b0);
        vq <= 16'h07d0;
        ana(16'sh023f, 16'sh0, 16'h0e10, 1'b0);
        vq <= 16'h03e8;
        $display("unipolar voltage done");
        pol <= 1'b1;
        pt[4] <= -16'sh00c8;
        pt[5] <= -16'sh03e8;
        pt[6] <= -16'sh0320;
        pt[7] <= -16'sh1f40;
        ana(-16'sh0320, 16'sh0, 16'h12c0, 1'b1);
        ana(-16'sh00c8, 16'sh0, 16'h0258, 1'b1);
        for (int k = 0; k < 4; k++) begin
            reverse_run <= k[0];
            forward_run <= ~k[0];
            vinv <= k[1];
            ana(-16'sh0320, 16'sh0, 16'h12c0, ~k[0] ^ k[1]);
            ana(16'sh01f4, 16'sh0, 16'h0bb8, k[0] ^ k[1]);
        end
        forward_run <= 1'b1;
        reverse_run <= 1'b0;
        vinv <= 1'b0;
        $display("bipolar voltage done");
        sel <= 4'h3;
        fs <= 16'h0fa0;
        ana(16'sh0, 16'sh07d0, 16'h0fa0, 1'b0);
        cq <= 16'h07d0;
        ana(16'sh0, 16'sh04b0, 16'h07d0, 1'b0);
        cq <= 16'h03e8;
        cinv <= 1'b1;
        ana(16'sh0, 16'sh04b0, 16'h07d0, 1'b1);
        cinv <= 1'b0;
        pt[11] <= 16'sh1388;
        ana(16'sh0, 16'sh07d0, 16'h07d0, 1'b0);
        pt[11] <= 16'sh2710;
        ana(16'sh0, 16'sh0, 16'h0000, 1'b0);
        cft <= 14'h0014;
        filt(16'sh0, 16'sh07d0, 16'h0fa0);
        $display("current input done");
        sel <= 4'h2;
        fs <= 16'h1770;
        pol <= 1'b0;
        pt[1] <= 16'sh07d0;
        ana(16'sh0, 16'sh0, 16'h04b0, 1'b0);
        pt[1] <= 16'sh0000;
        ana(16'sh0, 16'sh0, 16'h0000, 1'b0);
        vft <= 14'h0014;
        filt(16'sh03e8, 16'sh0, 16'h1770);
        vft <= 14'h0000;
        fs <= 16'h1b58;
        maxf <= 16'h1388;
        ana(16'sh03e8, 16'sh0, 16'h1388, 1'b0);
        $display("filter and clamp done");
        ce <= 1'b0;
        ana(16'sh01f4, 16'sh0, 16'h1388, 1'b0);
        check(vrb, 16'h03e8);
        ce <= 1'b1;
        ana(16'sh01f4, 16'sh0, 16'h09c4, 1'b0);
        sel <= 4'h5;
        wait_n(2);
        note(16'h0000, 1'b0);
        sel <= 4'h2;
        $display("enable and selector done");
        for (int i = 0; i < 8; i++) begin
            rv = afr_val_t'(int'($urandom_range(2000)) - 1000);
            rc = afr_val_t'($urandom_range(2000));
            afr_partner_i.drive(rv, rc);
            wait_n(2);
            @(negedge clk_i);
            check(vrb, rv);
            check(crb, rc);
        end
        $display("readback done");
        wrap_up();
    end
endmodule
